// ==== sbac_pkg.sv ====
/*
 Package for the quad-bank synchronous DRAM access core: geometry, command
 codes, burst encodings and timing counts.
 Assumes a single 40 MHz core clock; no software-visible registers.
*/
package sbac_pkg;
    localparam int SBAC_BANKS = 4;
    localparam int SBAC_ROW_W = 12;
    localparam int SBAC_ROWS = 4096;
    localparam int SBAC_COL_W = 10;
    localparam int SBAC_BA_W = 2;
    localparam int SBAC_CMD_W = 4;
    // Column counts per organisation
    localparam int SBAC_COLS_X4 = 1024;
    localparam int SBAC_COLS_X8 = 512;
    localparam int SBAC_COLS_X16 = 256;
    // Command codes presented on cmd
    localparam logic [3:0] SBAC_CMD_NOP = 4'h0;
    localparam logic [3:0] SBAC_CMD_ACT = 4'h1;
    localparam logic [3:0] SBAC_CMD_RD = 4'h2;
    localparam logic [3:0] SBAC_CMD_WR = 4'h3;
    localparam logic [3:0] SBAC_CMD_PRE = 4'h4;
    localparam logic [3:0] SBAC_CMD_PREALL = 4'h5;
    localparam logic [3:0] SBAC_CMD_BST = 4'h6;
    localparam logic [3:0] SBAC_CMD_AREF = 4'h7;
    localparam logic [3:0] SBAC_CMD_SREF = 4'h8;
    localparam logic [3:0] SBAC_CMD_PDN = 4'h9;
    localparam logic [3:0] SBAC_CMD_EXIT = 4'hA;
    localparam logic [3:0] SBAC_CMD_MODE = 4'hB;
    // Mode field layout on the address bus
    localparam int SBAC_MODE_BL_LSB = 0;
    localparam int SBAC_MODE_BT_BIT = 3;
    localparam int SBAC_MODE_RL_LSB = 4;
    localparam int SBAC_AP_BIT = 10;
    localparam logic [2:0] SBAC_BL_1 = 3'h0;
    localparam logic [2:0] SBAC_BL_2 = 3'h1;
    localparam logic [2:0] SBAC_BL_4 = 3'h2;
    localparam logic [2:0] SBAC_BL_8 = 3'h3;
    localparam logic [2:0] SBAC_BL_PAGE = 3'h7;
    localparam logic [2:0] SBAC_RL_RESET = 3'h2;
    // Self-timed precharge time in ns and derived cycles (rounded up)
    localparam int SBAC_CLK_NS = 25;
    localparam int SBAC_TRP_NS = 20;
    localparam int SBAC_TRP_CYC = (SBAC_TRP_NS + SBAC_CLK_NS - 1) / SBAC_CLK_NS;
    localparam int SBAC_CNT_W = 4;
    typedef enum logic [1:0] {SBAC_BK_IDLE, SBAC_BK_OPEN, SBAC_BK_PRECH} sbac_bank_e;
    typedef enum logic [2:0] {SBAC_PW_RUN, SBAC_PW_SREF, SBAC_PW_SREF_LP,
        SBAC_PW_PDN} sbac_power_e;
endpackage

// ==== sbac_bank.sv ====
/*
 One bank tracker: open row, pending auto precharge, self-timed precharge.
 Assumes commands are already decoded and qualified for this bank.
*/
`timescale 1ns/1ps
module sbac_bank
    import sbac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic do_act,
    input wire logic do_pre,
    input wire logic do_ap_arm,
    input wire logic burst_end,
    input wire logic [SBAC_ROW_W-1:0] row_in,
    output logic row_open,
    output logic [SBAC_ROW_W-1:0] open_row,
    output logic prech_busy
);
    sbac_bank_e state;
    logic ap_pending;
    logic [SBAC_CNT_W-1:0] cnt;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            ap_pending <= 1'b0;
        else if (do_ap_arm)
            ap_pending <= 1'b1;
        else if (burst_end || do_pre)
            ap_pending <= 1'b0;
    end

    // Precharge runs on its own counter, independent of other banks
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state <= SBAC_BK_IDLE;
            cnt <= '0;
            open_row <= '0;
        end
        else
        begin
            case (state)
                SBAC_BK_IDLE:
                    if (do_act)
                    begin
                        state <= SBAC_BK_OPEN;
                        open_row <= row_in;
                    end
                SBAC_BK_OPEN:
                    if (do_pre || (ap_pending && burst_end))
                    begin
                        state <= SBAC_BK_PRECH;
                        cnt <= SBAC_CNT_W'(SBAC_TRP_CYC);
                    end
                default:
                    if (cnt <= SBAC_CNT_W'(1))
                        state <= SBAC_BK_IDLE;
                    else
                        cnt <= cnt - SBAC_CNT_W'(1);
            endcase
        end
    end

    assign row_open = (state == SBAC_BK_OPEN);
    assign prech_busy = (state == SBAC_BK_PRECH);
endmodule

// ==== sbac_core.sv ====
/*
 Command and address core of a quad-bank synchronous DRAM: bank/row
 activation, programmable bursts with internal column generation, burst
 terminate, auto precharge, refresh and power modes.
 Assumes an external controller issuing one decoded command per clock.
*/
`timescale 1ns/1ps

module sbac_core
    import sbac_pkg::*;
#(
    parameter int COL_BITS = 10
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [SBAC_CMD_W-1:0] cmd,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [SBAC_ROW_W-1:0] row_column_address_bus,
    input wire logic low_power_sref,
    output logic burst_active,
    output logic burst_is_write,
    output logic [SBAC_BA_W-1:0] burst_bank,
    output logic [SBAC_ROW_W-1:0] burst_row,
    output logic [COL_BITS-1:0] burst_col,
    output logic [2:0] read_latency_cycles,
    output logic [SBAC_BANKS-1:0] bank_open,
    output logic [SBAC_BANKS-1:0] bank_precharging,
    output logic refresh_pulse,
    output logic [SBAC_ROW_W-1:0] refresh_row,
    output logic self_refresh,
    output logic power_down,
    output logic cmd_error
);
    logic [SBAC_BA_W-1:0] bank_in;
    logic [SBAC_BANKS-1:0] do_act;
    logic [SBAC_BANKS-1:0] do_pre;
    logic [SBAC_BANKS-1:0] do_ap_arm;
    logic [SBAC_BANKS-1:0] bk_end;
    logic [SBAC_BANKS-1:0][SBAC_ROW_W-1:0] bk_row;
    logic [2:0] burst_len;
    logic burst_interleave;
    logic [COL_BITS-1:0] start_col;
    logic [COL_BITS-1:0] beat;
    logic [COL_BITS-1:0] beats_left;
    logic [COL_BITS-1:0] next_beats;
    logic [COL_BITS-1:0] len_mask;
    logic is_col;
    logic col_ok;
    logic running;
    logic last_beat;
    sbac_power_e pstate;

    assign bank_in = {bank_select_high, bank_select_low};
    assign running = (pstate == SBAC_PW_RUN);
    assign is_col = running && (cmd == SBAC_CMD_RD || cmd == SBAC_CMD_WR);
    assign col_ok = is_col && bank_open[bank_in];

    ////////////////////////////////////////////////////////////////////////
    // Burst length decode
    always_comb
    begin
        case (burst_len)
            SBAC_BL_1: next_beats = COL_BITS'(1);
            SBAC_BL_2: next_beats = COL_BITS'(2);
            SBAC_BL_4: next_beats = COL_BITS'(4);
            SBAC_BL_8: next_beats = COL_BITS'(8);
            default: next_beats = '0; // Full row: wraps until terminated
        endcase
        len_mask = next_beats - COL_BITS'(1);
    end

    // Bursts wrap inside a block of their own length
    always_comb
    begin
        if (burst_len == SBAC_BL_PAGE)
            burst_col = start_col + beat;
        else if (burst_interleave)
            burst_col = (start_col & ~len_mask) | ((start_col ^ beat) & len_mask);
        else
            burst_col = (start_col & ~len_mask) | ((start_col + beat) & len_mask);
    end

    // A full-row burst never drains by count; only terminate or a new column ends it
    assign last_beat = burst_active && next_beats != '0 && beats_left == COL_BITS'(1);

    ////////////////////////////////////////////////////////////////////////
    // Mode configuration
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            burst_len <= SBAC_BL_1;
            burst_interleave <= 1'b0;
            read_latency_cycles <= SBAC_RL_RESET;
        end
        else if (running && cmd == SBAC_CMD_MODE && !burst_active)
        begin
            burst_len <= row_column_address_bus[SBAC_MODE_BL_LSB +: 3];
            burst_interleave <= row_column_address_bus[SBAC_MODE_BT_BIT];
            read_latency_cycles <= row_column_address_bus[SBAC_MODE_RL_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst engine; a new column command restarts it at once
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            burst_active <= 1'b0;
            burst_is_write <= 1'b0;
            burst_bank <= '0;
            burst_row <= '0;
            start_col <= '0;
            beat <= '0;
            beats_left <= '0;
        end
        else if (col_ok)
        begin
            burst_active <= 1'b1;
            burst_is_write <= (cmd == SBAC_CMD_WR);
            burst_bank <= bank_in;
            burst_row <= bk_row[bank_in];
            start_col <= row_column_address_bus[COL_BITS-1:0];
            beat <= '0;
            beats_left <= next_beats;
        end
        else if (burst_active && (cmd == SBAC_CMD_BST || last_beat))
            burst_active <= 1'b0;
        else if (burst_active)
        begin
            beat <= beat + COL_BITS'(1);
            beats_left <= beats_left - COL_BITS'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-bank command qualification and trackers
    genvar gi;
    generate
        for (gi = 0; gi < SBAC_BANKS; gi++)
        begin : g_bank
            assign do_act[gi] = running && cmd == SBAC_CMD_ACT && bank_in == SBAC_BA_W'(gi)
                && !bank_open[gi] && !bank_precharging[gi];
            // Precharge-all reaches every bank; an idle tracker simply ignores it
            assign do_pre[gi] = running && (cmd == SBAC_CMD_PREALL
                || (cmd == SBAC_CMD_PRE && bank_in == SBAC_BA_W'(gi)));
            assign do_ap_arm[gi] = col_ok && bank_in == SBAC_BA_W'(gi)
                && row_column_address_bus[SBAC_AP_BIT];
            // Ends when the burst drains, is cut short, or is replaced by any new column command to an open bank, this one or another
            assign bk_end[gi] = burst_active && burst_bank == SBAC_BA_W'(gi)
                && (last_beat || cmd == SBAC_CMD_BST || col_ok);
            sbac_bank u_bank
            (
                .core_clk(core_clk),
                .rst(rst),
                .do_act(do_act[gi]),
                .do_pre(do_pre[gi]),
                .do_ap_arm(do_ap_arm[gi]),
                .burst_end(bk_end[gi]),
                .row_in(row_column_address_bus),
                .row_open(bank_open[gi]),
                .open_row(bk_row[gi]),
                .prech_busy(bank_precharging[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Refresh row counter and power modes
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            refresh_pulse <= 1'b0;
            refresh_row <= '0;
        end
        else
        begin
            // Only legal with every bank idle; the controller keeps the rate
            refresh_pulse <= running && cmd == SBAC_CMD_AREF
                && bank_open == '0 && bank_precharging == '0;
            if (running && cmd == SBAC_CMD_AREF && bank_open == '0 && bank_precharging == '0)
                refresh_row <= refresh_row + SBAC_ROW_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            pstate <= SBAC_PW_RUN;
        else
        begin
            case (pstate)
                SBAC_PW_RUN:
                    if (cmd == SBAC_CMD_SREF && bank_open == '0 && !burst_active)
                        pstate <= low_power_sref ? SBAC_PW_SREF_LP : SBAC_PW_SREF;
                    else if (cmd == SBAC_CMD_PDN && !burst_active)
                        pstate <= SBAC_PW_PDN;
                default:
                    if (cmd == SBAC_CMD_EXIT)
                        pstate <= SBAC_PW_RUN;
            endcase
        end
    end

    assign self_refresh = (pstate == SBAC_PW_SREF) || (pstate == SBAC_PW_SREF_LP);
    assign power_down = (pstate == SBAC_PW_PDN);

    // Flags a column command to a closed bank or an activate on a busy one
    always_ff @(posedge core_clk)
    begin
        if (rst)
            cmd_error <= 1'b0;
        else
            cmd_error <= (is_col && !col_ok) || (running && cmd == SBAC_CMD_ACT
                && (bank_open[bank_in] || bank_precharging[bank_in]));
    end
endmodule

// ==== sbac_core_props.sv ====
/*
 Checker for the port behaviour of the DRAM access core.
 Assumes it is bound onto every sbac_core and sees only its ports.
*/
`timescale 1ns/1ps
module sbac_core_chk
    import sbac_pkg::*;
#(
    parameter int COL_BITS = 10
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [SBAC_CMD_W-1:0] cmd,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [SBAC_ROW_W-1:0] row_column_address_bus,
    input wire logic burst_active,
    input wire logic burst_is_write,
    input wire logic [SBAC_BA_W-1:0] burst_bank,
    input wire logic [SBAC_ROW_W-1:0] burst_row,
    input wire logic [COL_BITS-1:0] burst_col,
    input wire logic [2:0] read_latency_cycles,
    input wire logic [SBAC_BANKS-1:0] bank_open,
    input wire logic [SBAC_BANKS-1:0] bank_precharging,
    input wire logic refresh_pulse,
    input wire logic self_refresh,
    input wire logic power_down,
    input wire logic cmd_error
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic [1:0] bk;
    logic run;
    logic col_cmd;
    assign bk = {bank_select_high, bank_select_low};
    assign run = !self_refresh && !power_down;
    assign col_cmd = cmd == SBAC_CMD_RD || cmd == SBAC_CMD_WR;
    sequence s_bst_taken;
        cmd == SBAC_CMD_BST && burst_active && run;
    endsequence
    sequence s_burst_stops;
        ##1 !burst_active;
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) rst |=>
        read_latency_cycles == SBAC_RL_RESET && !burst_active && bank_open == '0)
        else $error("outputs not cleared by reset");
    a_act_opens_bank: assert property (cmd == SBAC_CMD_ACT && run &&
        !bank_open[bk] && !bank_precharging[bk] |=> bank_open[$past(bk)])
        else $error("activate did not open bank");
    a_col_start: assert property (col_cmd && run && bank_open[bk] |=>
        burst_active && burst_col == $past(row_column_address_bus[COL_BITS-1:0])
        && burst_bank == $past(bk) && burst_is_write == $past(cmd == SBAC_CMD_WR))
        else $error("burst start wrong");
    a_closed_refused: assert property (col_cmd && run && !bank_open[bk] |=> cmd_error)
        else $error("access to closed bank not flagged");
    a_reopen_refused: assert property (cmd == SBAC_CMD_ACT && run && bank_open[bk]
        |=> cmd_error) else $error("activate of open bank not flagged");
    a_bst_stops_burst: assert property (s_bst_taken |-> s_burst_stops)
        else $error("burst terminate ignored");
    a_burst_holds_row: assert property (burst_active && $past(burst_active) &&
        !$past(col_cmd) |-> $stable(burst_bank) && $stable(burst_row))
        else $error("burst bank or row moved");
    a_pre_closes_row: assert property (cmd == SBAC_CMD_PRE && run && bank_open[bk]
        |=> !bank_open[$past(bk)] && bank_precharging[$past(bk)])
        else $error("precharge did not close row");
    a_prech_one_cycle: assert property (|bank_precharging |=>
        (bank_precharging & $past(bank_precharging)) == '0)
        else $error("precharge longer than one cycle");
    a_aref_refused: assert property (cmd == SBAC_CMD_AREF && bank_open != '0
        |=> !refresh_pulse) else $error("refresh with open bank");
    a_pulse_cause: assert property (refresh_pulse |-> $past(cmd) == SBAC_CMD_AREF)
        else $error("refresh pulse without command");
    a_pdn_holds: assert property (power_down && cmd != SBAC_CMD_EXIT |=> power_down)
        else $error("power down left without exit");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind sbac_core sbac_core_chk #(.COL_BITS(COL_BITS)) i_sbac_core_chk (.core_clk, .rst, .cmd,
    .bank_select_low, .bank_select_high, .row_column_address_bus, .burst_active,
    .burst_is_write, .burst_bank, .burst_row, .burst_col, .read_latency_cycles, .bank_open,
    .bank_precharging, .refresh_pulse, .self_refresh, .power_down, .cmd_error);

// ==== sbac_ctrl_model.sv ====
/*
 Behavioural memory controller that issues one command per clock.
 Assumes the bench calls its tasks; issue drives at falling edges, set_lp drives at once.
*/
`timescale 1ns/1ps
module sbac_ctrl_model
    import sbac_pkg::*;
(
    input wire logic core_clk,
    output logic [SBAC_CMD_W-1:0] cmd,
    output logic bank_select_low,
    output logic bank_select_high,
    output logic [SBAC_ROW_W-1:0] row_column_address_bus,
    output logic low_power_sref
);
    initial
    begin
        cmd = SBAC_CMD_NOP;
        {bank_select_high, bank_select_low} = 2'h0;
        row_column_address_bus = 12'h000;
        low_power_sref = 1'b0;
    end
    // Bank and address stand for the whole cycle around the edge
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        @(negedge core_clk);
        cmd = c;
        {bank_select_high, bank_select_low} = b;
        // Address is meaningless on a no-op, so it toggles rather than lingers
        row_column_address_bus = (c == SBAC_CMD_NOP) ? ~row_column_address_bus : a;
    endtask
    task automatic set_lp(input logic v);
        low_power_sref = v;
    endtask
endmodule

// ==== sbac_core_tb_top.sv ====
/*
 Self-checking bench for the DRAM access core, one task per scenario.
 Assumes the controller model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module sbac_core_tb_top
    import sbac_pkg::*;
;
    logic core_clk, rst, bank_select_low, bank_select_high, low_power_sref;
    logic [3:0] cmd;
    logic [11:0] row_column_address_bus, burst_row, refresh_row;
    logic burst_active, burst_is_write, refresh_pulse, self_refresh, power_down, cmd_error;
    logic [1:0] burst_bank;
    logic [9:0] burst_col;
    logic [2:0] read_latency_cycles;
    logic [3:0] bank_open, bank_precharging;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    sbac_core #(.COL_BITS(10)) i_sbac_core (.core_clk, .rst, .cmd, .bank_select_low,
        .bank_select_high, .row_column_address_bus, .low_power_sref, .burst_active,
        .burst_is_write, .burst_bank, .burst_row, .burst_col, .read_latency_cycles, .bank_open,
        .bank_precharging, .refresh_pulse, .refresh_row, .self_refresh, .power_down, .cmd_error);
    sbac_ctrl_model i_sbac_ctrl_model (.core_clk, .cmd, .bank_select_low, .bank_select_high,
        .row_column_address_bus, .low_power_sref);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        i_sbac_ctrl_model.issue(c, b, a);
    endtask
    task automatic tally_and_finish();
        $display("checks_done %0d fail_count %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_ap_burst();
        logic [9:0] cols [4] = '{10'h006, 10'h007, 10'h004, 10'h005};
        go(SBAC_CMD_MODE, 2'h0, 12'h032);
        go(SBAC_CMD_ACT, 2'h1, 12'h005);
        go(SBAC_CMD_RD, 2'h1, 12'h406);
        chk("latency", 3, read_latency_cycles);
        chk("open", 4'h2, bank_open);
        foreach (cols[i])
        begin
            go(SBAC_CMD_NOP, 2'h0, 12'h000);
            chk("column", cols[i], burst_col);
        end
        chk("row", 12'h005, burst_row);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("active", 0, burst_active);
        chk("precharging", 4'h2, bank_precharging);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("closed", 0, bank_open | bank_precharging);
    endtask
    task automatic t_interleave();
        go(SBAC_CMD_MODE, 2'h0, 12'h02B);
        go(SBAC_CMD_ACT, 2'h2, 12'hFFF);
        go(SBAC_CMD_WR, 2'h2, 12'h003);
        go(SBAC_CMD_ACT, 2'h0, 12'h007);
        chk("column", 3, burst_col);
        chk("write", 1, burst_is_write);
        chk("row", 12'hFFF, burst_row);
        chk("bank", 2, burst_bank);
        go(SBAC_CMD_PRE, 2'h0, 12'h000);
        chk("column", 2, burst_col);
        chk("open", 4'h5, bank_open);
        go(SBAC_CMD_RD, 2'h2, 12'h009);
        chk("column", 1, burst_col);
        chk("precharging", 4'h1, bank_precharging);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("column", 9, burst_col);
        chk("write", 0, burst_is_write);
        go(SBAC_CMD_BST, 2'h0, 12'h000);
        chk("column", 8, burst_col);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("active", 0, burst_active);
    endtask
    task automatic t_refused();
        go(SBAC_CMD_RD, 2'h3, 12'h000);
        go(SBAC_CMD_ACT, 2'h2, 12'h001);
        chk("error", 1, cmd_error);
        go(SBAC_CMD_AREF, 2'h0, 12'h000);
        chk("error", 1, cmd_error);
        chk("open", 4'h4, bank_open);
        go(SBAC_CMD_PREALL, 2'h0, 12'h000);
        chk("refresh", 0, refresh_pulse);
        go(SBAC_CMD_ACT, 2'h2, 12'h001);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("error", 1, cmd_error);
        chk("open", 0, bank_open);
        go(SBAC_CMD_AREF, 2'h0, 12'h000);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("refresh", 1, refresh_pulse);
        chk("refresh row", 1, refresh_row);
    endtask
    task automatic t_power();
        i_sbac_ctrl_model.set_lp(1'b1);
        go(SBAC_CMD_SREF, 2'h0, 12'h000);
        go(SBAC_CMD_ACT, 2'h1, 12'h000);
        chk("self refresh", 1, self_refresh);
        go(SBAC_CMD_EXIT, 2'h0, 12'h000);
        go(SBAC_CMD_PDN, 2'h0, 12'h000);
        chk("ignored", 0, bank_open);
        chk("self refresh", 0, self_refresh);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("power down", 1, power_down);
        go(SBAC_CMD_EXIT, 2'h0, 12'h000);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("power down", 0, power_down);
    endtask
    task automatic t_page_reset();
        go(SBAC_CMD_MODE, 2'h0, 12'h077);
        go(SBAC_CMD_ACT, 2'h1, 12'h00A);
        go(SBAC_CMD_RD, 2'h1, 12'h3FF);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("column", 10'h3FF, burst_col);
        chk("latency", 7, read_latency_cycles);
        go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("column", 10'h000, burst_col);
        // A full-row burst must still run after one whole lap of the row
        repeat (1023) go(SBAC_CMD_NOP, 2'h0, 12'h000);
        chk("active", 1, burst_active);
        chk("column", 10'h3FF, burst_col);
        rst = 1'b1;
        repeat (2) go(SBAC_CMD_NOP, 2'h0, 12'h000);
        rst = 1'b0;
        chk("active", 0, burst_active);
        chk("open", 0, bank_open);
        chk("latency", 2, read_latency_cycles);
        chk("refresh row", 0, refresh_row);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Whole run needs about 1100 cycles; the ceiling leaves ample slack
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles >= 2000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk("latency", 2, read_latency_cycles);
        chk("active", 0, burst_active);
        t_ap_burst();
        t_interleave();
        t_refused();
        t_power();
        t_page_reset();
        tally_and_finish();
    end
endmodule
